// [rtl/glhp_pkg.sv]
// Package with constants and types of the graphic display host port
package glhp_pkg;
    // Host access decoded from register select and read/write
    typedef enum logic [3:0] {
        GLHP_OP_INSTR_WR = 4'h1,
        GLHP_OP_STAT_RD = 4'h2,
        GLHP_OP_DATA_WR = 4'h4,
        GLHP_OP_DATA_RD = 4'h8
    } glhp_op_e;

    // Drain engine states
    typedef enum logic [2:0] {
        GLHP_ST_IDLE = 3'h1,
        GLHP_ST_EXEC = 3'h2,
        GLHP_ST_HOLD = 3'h4
    } glhp_st_e;

    // Bus and memory widths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned COL_W = 6;
    localparam int unsigned PAGE_W = 3;
    localparam int unsigned LINE_W = 6;
    localparam int unsigned ADDR_W = PAGE_W + COL_W;
    localparam int unsigned RAM_DEPTH = 512;
    localparam int unsigned FIFO_W = DATA_W + 1;
    localparam int unsigned FIFO_DEPTH = 8;

    // Instruction patterns
    localparam logic [6:0] ONOFF_PAT = 7'h1f;
    localparam logic [1:0] COL_PAT = 2'h1;
    localparam logic [4:0] PAGE_PAT = 5'h17;
    localparam logic [1:0] LINE_PAT = 2'h3;

    // Status byte bit positions
    localparam int unsigned ST_BUSY_BIT = 7;
    localparam int unsigned ST_OFF_BIT = 5;
    localparam int unsigned ST_RST_BIT = 4;

    // Reset values, column limit and step increments
    localparam logic [LINE_W-1:0] LINE_RST = 6'h00;
    localparam logic [COL_W-1:0] COL_RST = 6'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
    localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
    localparam logic [COL_W-1:0] COL_MAX = 6'h3f;
    localparam logic [COL_W-1:0] COL_ONE = 6'h01;
    localparam logic [LINE_W-1:0] LINE_ONE = 6'h01;

    // Internal operation time, rounded up to whole clock cycles
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned OP_TIME_PS = 15000;
    localparam int unsigned OP_CYCLES = (OP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] OP_CNT_LAST = 4'(OP_CYCLES - 1);
    localparam logic [3:0] OP_CNT_ZERO = 4'h0;
    localparam logic [3:0] OP_CNT_ONE = 4'h1;
endpackage

// [rtl/glhp_fifo.sv]
// Small synchronous FIFO that holds host writes until they are executed
`timescale 1ns/1ps
module glhp_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes; full and empty come straight from the fill count
    assign in_ready_o = (count_r != (PW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rd_ptr_r];

    // Storage, written only on an accepted push
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// [rtl/glhp_top.sv]
// Host parallel port, display RAM and display control of the graphic display controller
// Notes on behaviour
// - Without both chip selects active, nothing is accepted, returned or changed.
// - Reset input and segment direction act regardless of chip selects.
// - Written byte is latched on the strobe, then moved to RAM internally.
// - Data read returns the output register, then reloads it from RAM.
// - Status read returns current status at once, no dummy read.
// - Select/read decode: instruction write, status read, data write, data read.
// - Reset input low turns display off and clears the start line.
// - While reset input is low only status read is accepted.
// - Busy flag on bit seven, high while an internal operation runs.
// - Off flip-flop set forces all segments non-selected, else RAM data shows.
// - Off flip-flop changes by instruction or reset input low; shown on bit five.
// - Segment data blank while the reset input is low.
// - Page register never counts; only the page-set instruction loads it.
// - Column counter loads by instruction, increments after each data access.
// - RAM bit one lights its dot, zero leaves it dark.
// - Start line latched from low six bits, preset into line counter on frame.
// - Pattern 0011111 plus flag; flag one shows RAM, zero blanks.
// - Pattern 01 plus six-bit column loads the column counter.
// - Pattern 10111 plus three-bit page selects page for later accesses.
// - Status bit four is reset in progress; bits six, three to zero read zero.
`timescale 1ns/1ps
module glhp_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chip_select_left_i,
    input wire logic chip_select_right_i,
    input wire logic register_select_i,
    input wire logic read_write_i,
    input wire logic enable_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    input wire logic reset_n_input_i,
    input wire logic segment_dir_i,
    input wire logic frame_pulse_i,
    input wire logic line_step_i,
    input wire logic [5:0] scan_col_i,
    output logic [5:0] line_addr_o,
    output logic [7:0] seg_data_o,
    output logic busy_o,
    output logic display_off_o
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic enable_q_r;
    logic enable_rise;
    logic enable_fall;
    logic selected;
    glhp_pkg::glhp_op_e host_op;
    logic take_wr;
    logic take_rd;
    logic take_stat;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [glhp_pkg::FIFO_W-1:0] fifo_out_data;
    logic entry_is_data;
    logic [glhp_pkg::DATA_W-1:0] entry_byte;
    glhp_pkg::glhp_st_e state_r;
    logic [3:0] op_cnt_r;
    logic [glhp_pkg::PAGE_W-1:0] page_r;
    logic [glhp_pkg::COL_W-1:0] col_r;
    logic [glhp_pkg::LINE_W-1:0] start_line_r;
    logic [glhp_pkg::LINE_W-1:0] line_cnt_r;
    logic off_ff_r;
    logic [glhp_pkg::DATA_W-1:0] out_reg_r;
    logic [glhp_pkg::DATA_W-1:0] data_r;
    logic [glhp_pkg::DATA_W-1:0] status;
    logic load_pend_r;
    logic [glhp_pkg::DATA_W-1:0] ram_r [glhp_pkg::RAM_DEPTH];
    logic [glhp_pkg::DATA_W-1:0] host_q_r;
    logic [glhp_pkg::DATA_W-1:0] scan_q_r;
    logic busy;
    logic pop_entry;
    logic pop_instr;
    logic pop_data;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Both chip selects must be active for any host access
    function automatic logic chip_sel(input logic left, input logic right);
        chip_sel = left && right;
    endfunction

    // Select and read/write decode
    function automatic glhp_pkg::glhp_op_e op_decode(input logic rsel, input logic rd);
        unique case ({rsel, rd})
            2'b00: op_decode = glhp_pkg::GLHP_OP_INSTR_WR;
            2'b01: op_decode = glhp_pkg::GLHP_OP_STAT_RD;
            2'b10: op_decode = glhp_pkg::GLHP_OP_DATA_WR;
            default: op_decode = glhp_pkg::GLHP_OP_DATA_RD;
        endcase
    endfunction

    // RAM index from page and column
    function automatic logic [glhp_pkg::ADDR_W-1:0] ram_index(
        input logic [glhp_pkg::PAGE_W-1:0] pg,
        input logic [glhp_pkg::COL_W-1:0] cl
    );
        ram_index = {pg, cl};
    endfunction

    // Column set: opcode above the column value
    function automatic logic is_col_set(input logic [glhp_pkg::DATA_W-1:0] b);
        is_col_set = (b[glhp_pkg::DATA_W-1:glhp_pkg::COL_W] == glhp_pkg::COL_PAT);
    endfunction

    // Page set: opcode above the page number
    function automatic logic is_page_set(input logic [glhp_pkg::DATA_W-1:0] b);
        is_page_set = (b[glhp_pkg::DATA_W-1:glhp_pkg::PAGE_W] == glhp_pkg::PAGE_PAT);
    endfunction

    // Start line: opcode above the line number
    function automatic logic is_line_set(input logic [glhp_pkg::DATA_W-1:0] b);
        is_line_set = (b[glhp_pkg::DATA_W-1:glhp_pkg::LINE_W] == glhp_pkg::LINE_PAT);
    endfunction

    // Display switch: opcode above the on flag in the lowest bit
    function automatic logic is_onoff(input logic [glhp_pkg::DATA_W-1:0] b);
        is_onoff = (b[glhp_pkg::DATA_W-1:glhp_pkg::DATA_W-$bits(glhp_pkg::ONOFF_PAT)]
            == glhp_pkg::ONOFF_PAT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Host strobe handling; reads act on the rising edge, writes on the fall
    assign selected = chip_sel(chip_select_left_i, chip_select_right_i);
    assign host_op = op_decode(register_select_i, read_write_i);
    assign enable_rise = enable_i && !enable_q_r;
    assign enable_fall = !enable_i && enable_q_r;

    // Writes are refused while busy, in reset or with a full input register
    assign take_wr = enable_fall && selected && !read_write_i && reset_n_input_i
        && !busy && fifo_in_ready;
    assign take_stat = enable_rise && selected && (host_op == glhp_pkg::GLHP_OP_STAT_RD);
    assign take_rd = enable_rise && selected && reset_n_input_i
        && (host_op == glhp_pkg::GLHP_OP_DATA_RD) && !busy;

    // Previous strobe level for edge detection
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            enable_q_r <= 1'b0;
        end else begin
            enable_q_r <= enable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input holding register: writes queue here and drain without host help
    glhp_fifo #(
        .WIDTH(glhp_pkg::FIFO_W),
        .DEPTH(glhp_pkg::FIFO_DEPTH)
    ) u_in_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(take_wr),
        .in_ready_o(fifo_in_ready),
        .in_data_i({register_select_i, data_i}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    assign entry_is_data = fifo_out_data[glhp_pkg::DATA_W];
    assign entry_byte = fifo_out_data[glhp_pkg::DATA_W-1:0];

    // Pop qualifiers shared by every register that an entry updates
    assign pop_entry = fifo_out_valid && fifo_out_ready;
    assign pop_instr = pop_entry && !entry_is_data;
    assign pop_data = pop_entry && entry_is_data;

    // One entry is popped per internal operation; the engine stalls the queue
    assign fifo_out_ready = (state_r == glhp_pkg::GLHP_ST_IDLE) && !load_pend_r;

    // Busy covers queued writes, a running operation and a pending RAM load
    // A write while busy is dropped, not queued, so the host must poll first
    assign busy = fifo_out_valid || (state_r != glhp_pkg::GLHP_ST_IDLE) || load_pend_r;
    assign busy_o = busy;

    ////////////////////////////////////////////////////////////////////////
    // Drain engine: runs an operation for a fixed number of cycles
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= glhp_pkg::GLHP_ST_IDLE;
            op_cnt_r <= glhp_pkg::OP_CNT_ZERO;
        end else begin
            unique case (state_r)
                glhp_pkg::GLHP_ST_IDLE: begin
                    if (pop_entry) begin
                        state_r <= glhp_pkg::GLHP_ST_EXEC;
                        op_cnt_r <= glhp_pkg::OP_CNT_LAST;
                    end
                end
                glhp_pkg::GLHP_ST_EXEC: begin
                    if (op_cnt_r <= glhp_pkg::OP_CNT_ONE) begin
                        state_r <= glhp_pkg::GLHP_ST_HOLD;
                    end else begin
                        op_cnt_r <= op_cnt_r - glhp_pkg::OP_CNT_ONE;
                    end
                end
                glhp_pkg::GLHP_ST_HOLD: begin
                    state_r <= glhp_pkg::GLHP_ST_IDLE;
                    op_cnt_r <= glhp_pkg::OP_CNT_ZERO;
                end
                default: begin
                    state_r <= glhp_pkg::GLHP_ST_IDLE;
                    op_cnt_r <= glhp_pkg::OP_CNT_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display RAM; a one stored lights the dot, the byte is the column slice
    always_ff @(posedge mclk_i) begin
        if (pop_data) begin
            ram_r[ram_index(page_r, col_r)] <= entry_byte;
        end
    end

    // Registered host read port, sampled when a data read is taken
    always_ff @(posedge mclk_i) begin
        if (take_rd) begin
            host_q_r <= ram_r[ram_index(page_r, col_r)];
        end
    end

    // Registered scan port; segment direction mirrors the column order
    always_ff @(posedge mclk_i) begin
        scan_q_r <= ram_r[ram_index(line_cnt_r[glhp_pkg::LINE_W-1:glhp_pkg::COL_W-glhp_pkg::PAGE_W],
            segment_dir_i ? (glhp_pkg::COL_MAX - scan_col_i) : scan_col_i)];
    end

    ////////////////////////////////////////////////////////////////////////
    // Output holding register: reloaded one cycle after each data read
    // The byte read is the one loaded by the data read before it; the first read after reset returns zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            load_pend_r <= 1'b0;
            out_reg_r <= glhp_pkg::BYTE_RST;
        end else begin
            load_pend_r <= take_rd;
            if (load_pend_r) begin
                out_reg_r <= host_q_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode and column counter
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            col_r <= glhp_pkg::COL_RST;
        end else if (pop_instr && is_col_set(entry_byte)) begin
            col_r <= entry_byte[glhp_pkg::COL_W-1:0];
        end else if (pop_data || load_pend_r) begin
            col_r <= col_r + glhp_pkg::COL_ONE;
        end
    end

    // Page register: loaded only, never counted
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            page_r <= glhp_pkg::PAGE_RST;
        end else if (pop_instr && is_page_set(entry_byte)) begin
            page_r <= entry_byte[glhp_pkg::PAGE_W-1:0];
        end
    end

    // Start line register; the reset input clears it at any time
    always_ff @(posedge mclk_i) begin
        if (rst_i || !reset_n_input_i) begin
            start_line_r <= glhp_pkg::LINE_RST;
        end else if (pop_instr && is_line_set(entry_byte)) begin
            start_line_r <= entry_byte[glhp_pkg::LINE_W-1:0];
        end
    end

    // Display off flip-flop: set by the reset input, otherwise only by instruction
    always_ff @(posedge mclk_i) begin
        if (rst_i || !reset_n_input_i) begin
            off_ff_r <= 1'b1;
        end else if (pop_instr && is_onoff(entry_byte)) begin
            off_ff_r <= !entry_byte[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line address counter, preset from the start line while frame is high
    // Stepping wraps after the last line, as the counter is six bits wide
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            line_cnt_r <= glhp_pkg::LINE_RST;
        end else if (frame_pulse_i) begin
            line_cnt_r <= start_line_r;
        end else if (line_step_i) begin
            line_cnt_r <= line_cnt_r + glhp_pkg::LINE_ONE;
        end
    end

    assign line_addr_o = line_cnt_r;
    assign display_off_o = off_ff_r;

    // Segment data: blanked while off or in reset; RAM bits shown directly
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            seg_data_o <= glhp_pkg::BYTE_RST;
        end else if (off_ff_r || !reset_n_input_i) begin
            seg_data_o <= glhp_pkg::BYTE_RST;
        end else begin
            seg_data_o <= scan_q_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte; unused bits are constant zero
    // Built fresh every cycle, so a status read never needs a dummy access
    always_comb begin
        status = glhp_pkg::BYTE_RST;
        status[glhp_pkg::ST_BUSY_BIT] = busy;
        status[glhp_pkg::ST_OFF_BIT] = off_ff_r;
        status[glhp_pkg::ST_RST_BIT] = !reset_n_input_i;
    end

    // Read data register: captured at the strobe's rising edge
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            data_r <= glhp_pkg::BYTE_RST;
        end else if (take_stat) begin
            data_r <= status;
        end else if (take_rd) begin
            data_r <= out_reg_r;
        end
    end

    // Drive the bus only during a selected read strobe
    // Enable waits for the registered byte, so no stale byte is shown unless a data read is refused while busy or in reset
    assign data_o = data_r;
    assign data_oe_n_o = !(selected && read_write_i && enable_i && enable_q_r);
endmodule

// [bench/glhp_host_model.sv]
// Host processor model driving the parallel bus of the display port
`timescale 1ns/1ps
module glhp_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    output logic cs_l_o,
    output logic cs_r_o,
    output logic rs_o,
    output logic rw_o,
    output logic en_o,
    output logic [7:0] wdata_o
);
    // Idle bus at time zero
    initial begin
        {cs_l_o, cs_r_o, rs_o, rw_o, en_o} = 5'h00;
        wdata_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // One bus cycle; hold stretches the strobe to play a slow host.
    // A released bus shows the inverse, so stale bytes never look valid.
    task automatic access(input logic [1:0] cs, input logic rs, input logic rw,
            input logic [7:0] wd, input int hold, output logic [7:0] rd);
        @(posedge mclk_i);
        {cs_l_o, cs_r_o} <= cs;
        rs_o <= rs;
        rw_o <= rw;
        wdata_o <= rw ? ~wdata_o : wd;
        en_o <= 1'b1;
        repeat (hold + 3) @(posedge mclk_i);
        rd = rdata_i;
        en_o <= 1'b0;
        @(posedge mclk_i);
        {cs_l_o, cs_r_o} <= 2'b00;
        wdata_o <= ~wdata_o;
    endtask
endmodule

// [bench/glhp_top_properties.sv]
// Port-level checks of the graphic display host port
`timescale 1ns/1ps
module glhp_top_properties (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic chip_select_left_i,
    input wire logic chip_select_right_i,
    input wire logic register_select_i,
    input wire logic read_write_i,
    input wire logic enable_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic reset_n_input_i,
    input wire logic frame_pulse_i,
    input wire logic [5:0] line_addr_o,
    input wire logic [7:0] seg_data_o,
    input wire logic busy_o,
    input wire logic display_off_o
);
    logic en_q_r;
    logic [3:0] since_ctl_r;
    wire logic sel = chip_select_left_i && chip_select_right_i;
    wire logic take_rd = sel && read_write_i && enable_i && !en_q_r;
    wire logic take_wr = sel && !read_write_i && !enable_i && en_q_r;
    // Strobe history, so edges of the strobe can be seen
    always_ff @(posedge mclk_i) begin
        en_q_r <= enable_i;
    end
    // Cycles since an instruction write or the device reset input
    always_ff @(posedge mclk_i) begin
        if (rst_i || !reset_n_input_i || (take_wr && !register_select_i)) begin
            since_ctl_r <= 4'h0;
        end else if (since_ctl_r != 4'hf) begin
            since_ctl_r <= since_ctl_r + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    AST_UNSEL_QUIET: assert property (!sel |-> data_oe_n_o)
        else $error("bus driven while unselected");
    AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(sel))
        else $error("busy without a selected access");
    AST_OE_READ: assert property (sel && read_write_i && enable_i && en_q_r && $past(en_q_r)
        |-> !data_oe_n_o)
        else $error("bus not driven on read");
    AST_READ_DATA: assert property ($changed(data_o) |-> $past(take_rd))
        else $error("read data moved without a read");
    AST_WR_BUSY: assert property (take_wr && !busy_o && reset_n_input_i |=> busy_o)
        else $error("busy missing after write");
    AST_BUSY_END: assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
        else $error("busy stuck");
    AST_OFF_BY_CMD: assert property ($changed(display_off_o) |-> since_ctl_r < 4'h8)
        else $error("display flag changed without instruction");
    AST_RSTIN_OFF: assert property (!reset_n_input_i [*3] |-> display_off_o)
        else $error("display on under reset input");
    AST_RSTIN_BLANK: assert property (!reset_n_input_i [*4] |-> seg_data_o == 8'h00)
        else $error("segments lit under reset input");
    AST_OFF_BLANK: assert property (display_off_o [*4] |-> seg_data_o == 8'h00)
        else $error("segments lit while off");
    AST_FRAME_HOLD: assert property (frame_pulse_i [*3] |-> $stable(line_addr_o))
        else $error("line moved during frame preset");
    COV_INSTR: cover property (take_wr && !register_select_i);
    COV_DATA_RD: cover property (take_rd && register_select_i);
    COV_RSTIN: cover property (!reset_n_input_i [*4]);
endmodule
bind glhp_top glhp_top_properties u_props (
    .mclk_i(mclk_i), .rst_i(rst_i), .chip_select_left_i(chip_select_left_i),
    .chip_select_right_i(chip_select_right_i), .register_select_i(register_select_i),
    .read_write_i(read_write_i), .enable_i(enable_i), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .reset_n_input_i(reset_n_input_i),
    .frame_pulse_i(frame_pulse_i), .line_addr_o(line_addr_o), .seg_data_o(seg_data_o),
    .busy_o(busy_o), .display_off_o(display_off_o)
);

// [bench/glhp_top_tb.sv]
// Self-checking bench for the graphic display host port
`timescale 1ns/1ps
module glhp_top_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rst_in_n = 1'b0;
    logic seg_dir = 1'b0;
    logic frame = 1'b0;
    logic step = 1'b0;
    logic [5:0] scol = 6'h00;
    logic cs_l, cs_r, rs, rw, en, oe_n, busy, off;
    logic [7:0] bus, dout, seg;
    logic [5:0] line;
    logic [7:0] mem [512];
    logic [31:0] seed = 32'h00015a23;
    int err_count = 0;
    int checks_done = 0;
    always #2.5 mclk_i = ~mclk_i;
    glhp_host_model u_host (.mclk_i(mclk_i), .rdata_i(dout), .cs_l_o(cs_l), .cs_r_o(cs_r),
        .rs_o(rs), .rw_o(rw), .en_o(en), .wdata_o(bus));
    glhp_top u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .chip_select_left_i(cs_l),
        .chip_select_right_i(cs_r), .register_select_i(rs), .read_write_i(rw),
        .enable_i(en), .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n),
        .reset_n_input_i(rst_in_n), .segment_dir_i(seg_dir), .frame_pulse_i(frame),
        .line_step_i(step), .scan_col_i(scol), .line_addr_o(line), .seg_data_o(seg),
        .busy_o(busy), .display_off_o(off)
    );
    ////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed seed for repeatable runs
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected status byte
    function automatic logic [7:0] stat_exp(input logic b, input logic o, input logic r);
        return {b, 1'b0, o, r, 4'h0};
    endfunction
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus cycle with a random strobe length
    task automatic xfer(input logic [1:0] cs, input logic rsv, input logic rwv,
            input logic [7:0] wd, output logic [7:0] r);
        u_host.access(cs, rsv, rwv, wd, int'(rnd() % 3), r);
    endtask
    // Poll status until neither busy nor in reset; bounded
    task automatic wait_ready();
        logic [7:0] s;
        for (int i = 0; i < 40; i++) begin
            xfer(2'b11, 1'b0, 1'b1, 8'h00, s);
            if (s[7] === 1'b0 && s[4] === 1'b0) return;
        end
        err_count++;
        end_of_test();
    endtask
    task automatic wr(input logic rsv, input logic [7:0] wd);
        logic [7:0] r;
        wait_ready();
        xfer(2'b11, rsv, 1'b0, wd, r);
    endtask
    task automatic rdd(output logic [7:0] r);
        wait_ready();
        xfer(2'b11, 1'b1, 1'b1, 8'h00, r);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] r;
        logic [5:0] c0;
        logic [5:0] ln;
        logic [2:0] page;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rst_in_n <= 1'b1;
        @(posedge mclk_i);
        xfer(2'b11, 1'b0, 1'b1, 8'h00, r);
        chk("status", stat_exp(1'b0, 1'b1, 1'b0), r);
        // Both on/off codes, ending with the display on
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, {glhp_pkg::ONOFF_PAT, ~i[0]});
            wait_ready();
            chk("off flag", {7'h00, i[0]}, {7'h00, off});
            xfer(2'b11, 1'b0, 1'b1, 8'h00, r);
            chk("status", stat_exp(1'b0, i[0], 1'b0), r);
        end
        // Device reset input with both chips selected: status read and a refused display-on write
        wr(1'b0, {glhp_pkg::LINE_PAT, 6'h09});
        wait_ready();
        rst_in_n <= 1'b0;
        xfer(2'b11, 1'b0, 1'b1, 8'h00, r);
        chk("status in reset", stat_exp(1'b0, 1'b1, 1'b1), r);
        xfer(2'b11, 1'b0, 1'b0, {glhp_pkg::ONOFF_PAT, 1'b1}, r);
        frame <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk("off in reset", 8'h01, {7'h00, off});
        chk("line in reset", 8'h00, {2'b00, line});
        chk("seg in reset", 8'h00, seg);
        frame <= 1'b0;
        rst_in_n <= 1'b1;
        wait_ready();
        chk("off kept", 8'h01, {7'h00, off});
        wr(1'b0, {glhp_pkg::ONOFF_PAT, 1'b1});
        // Random pages and columns, first run wraps the column
        for (int k = 0; k < 4; k++) begin
            page = 3'(rnd());
            c0 = (k == 0) ? 6'h3e : 6'(rnd());
            wr(1'b0, {glhp_pkg::PAGE_PAT, page});
            wr(1'b0, {glhp_pkg::COL_PAT, c0});
            for (int j = 0; j < 3; j++) begin
                r = 8'(rnd());
                wr(1'b1, r);
                mem[{page, 6'(c0 + j)}] = r;
            end
            wr(1'b0, {glhp_pkg::COL_PAT, c0});
            xfer(2'b01, 1'b1, 1'b0, 8'h5a, r);
            rdd(r);
            for (int j = 0; j < 3; j++) begin
                rdd(r);
                chk("ram byte", mem[{page, 6'(c0 + j)}], r);
            end
        end
        // Scan path: start line preset, both scan directions, blanking
        ln = {page, 3'(rnd())};
        wr(1'b0, {glhp_pkg::LINE_PAT, ln});
        wait_ready();
        frame <= 1'b1;
        scol <= c0;
        repeat (4) @(posedge mclk_i);
        chk("line preset", {2'b00, ln}, {2'b00, line});
        chk("seg byte", mem[{page, c0}], seg);
        frame <= 1'b0;
        seg_dir <= 1'b1;
        scol <= 6'h3f - c0;
        repeat (4) @(posedge mclk_i);
        chk("seg mirrored", mem[{page, c0}], seg);
        step <= 1'b1;
        @(posedge mclk_i);
        step <= 1'b0;
        @(posedge mclk_i);
        chk("line step", {2'b00, ln + 6'h01}, {2'b00, line});
        wr(1'b0, {glhp_pkg::ONOFF_PAT, 1'b0});
        wait_ready();
        repeat (4) @(posedge mclk_i);
        chk("seg off", 8'h00, seg);
        end_of_test();
    end
endmodule
